// ### src/mmg_guard.sv
/*
 Monitor memory guard: mode control, interrupt gating, job and port
 access checking with relocation. One clock, synchronous reset.
 Assumes the port controllers drive their interrupt lines asynchronously
 and their access requests on this clock.
*/
`timescale 1ns/100ps
`default_nettype none
module mmg_guard
(
	input  wire logic                        clk_sys_in,
	input  wire logic                        reset_in,
	input  wire logic                        exec_start_in,
	input  wire logic                        monitor_exit_in,
	input  wire logic [mmg_pkg::MMG_NPORTS-1:0] port_irq_in,
	input  wire logic                        bounds_wr_in,
	input  wire mmg_pkg::mmg_bounds_type     bounds_in,
	input  wire logic [31:0]                 inter_installed_in,
	input  wire logic [31:0]                 backing_installed_in,
	input  wire mmg_pkg::mmg_req_type        req_in,
	input  wire mmg_pkg::mmg_port_req_type   port_req_in,
	output mmg_pkg::mmg_grant_type           grant_out,
	output logic                             deny_out,
	output logic                             port_grant_out,
	output logic                             port_deny_out,
	output logic                             interrupt_out,
	output mmg_pkg::mmg_cause_type           cause_out,
	output logic                             monitor_mode_out,
	output logic                             deadstart_out,
	output mmg_pkg::mmg_bounds_type          bounds_out
);
	import mmg_pkg::*;

	mmg_mode_type              mode_r;
	mmg_mode_type              mode_nxt;
	logic                      deadstart_r;
	mmg_bounds_type            bounds_r;
	logic [MMG_NPORTS-1:0]     irq_s1_r;
	logic [MMG_NPORTS-1:0]     irq_s2_r;
	logic [MMG_NPORTS-1:0]     irq_s3_r;
	logic [MMG_NPORTS-1:0]     irq_lvl_r;
	mmg_grant_type             grant_r;
	logic                      deny_r;
	logic                      port_grant_r;
	logic                      port_deny_r;
	logic                      irq_r;
	mmg_cause_type             cause_r;
	mmg_cause_type             cause_nxt;

	wire logic [31:0] inter_phys;
	wire logic        inter_inb;
	wire logic        inter_pres;
	wire logic [31:0] back_phys;
	wire logic [31:0] back_upper;
	wire logic        back_inb;
	wire logic        back_pres;
	wire logic        in_monitor;
	wire logic        is_main;
	wire logic        is_inter;
	wire logic        is_back;
	wire logic        job_main_ok;
	wire logic        job_inter_ok;
	wire logic        job_back_ok;
	wire logic        job_absent;
	wire logic        job_ok;
	wire logic        mon_ok;
	wire logic        access_ok;
	wire logic        job_fault;
	wire logic        port_irq_any;
	wire logic        take_irq;
	wire logic        port_ok;
	wire logic [31:0] grant_phys;

	mmg_reloc u_inter
	(
		.offset_in    (req_in.addr),
		.lower_in     (bounds_r.inter_lower),
		.upper_in     (bounds_r.inter_upper),
		.installed_in (inter_installed_in),
		.phys_out     (inter_phys),
		.in_bounds_out(inter_inb),
		.present_out  (inter_pres)
	);

	assign back_upper = bounds_r.backing_upper;

	mmg_reloc u_back
	(
		.offset_in    (req_in.addr),
		.lower_in     (bounds_r.backing_lower),
		.upper_in     (back_upper),
		.installed_in (backing_installed_in),
		.phys_out     (back_phys),
		.in_bounds_out(back_inb),
		.present_out  (back_pres)
	);

	// access decode
	assign in_monitor   = (mode_r == MMG_MONITOR);
	assign is_main      = (req_in.space == MMG_SP_MAIN);
	assign is_inter     = (req_in.space == MMG_SP_INTER);
	assign is_back      = (req_in.space == MMG_SP_BACKING);
	assign job_main_ok  = (req_in.addr >= MMG_MON_WORDS);
	assign job_inter_ok = inter_inb && inter_pres && (inter_phys >= MMG_MON_WORDS);
	assign job_back_ok  = back_inb && back_pres;
	assign job_absent   = (is_inter && !inter_pres) || (is_back && !back_pres);
	assign job_ok       = is_main ? job_main_ok : (is_inter ? job_inter_ok : (is_back && job_back_ok));
	// monitor: fetch only from low main, data anywhere
	assign mon_ok       = (req_in.kind == MMG_K_FETCH) ? (is_main && req_in.addr < MMG_MON_FETCH) : 1'b1;
	assign access_ok    = in_monitor ? mon_ok : job_ok;
	assign job_fault    = req_in.valid && !in_monitor && !job_ok;
	assign port_irq_any = |irq_lvl_r;
	assign take_irq     = !in_monitor && (port_irq_any || job_fault);
	assign grant_phys   = (in_monitor || is_main) ? req_in.addr : (is_inter ? inter_phys : back_phys);
	assign port_ok      = deadstart_r || (port_req_in.addr >= MMG_KERNEL_WORDS);
	assign mode_nxt     = take_irq ? MMG_MONITOR : ((in_monitor && monitor_exit_in) ? MMG_JOB : mode_r);
	assign cause_nxt    = !take_irq ? cause_r :
	                      (job_fault ? (job_absent ? MMG_C_ABSENT : MMG_C_BOUNDS) : MMG_C_PORT);

	// three-stage pin synchroniser per interrupt line
	genvar g;
	generate
		for (g = 0; g < MMG_NPORTS; g++)
		begin : g_sync
			always_ff @(posedge clk_sys_in)
			begin
				if (reset_in)
				begin
					irq_s1_r[g]  <= 1'b0;
					irq_s2_r[g]  <= 1'b0;
					irq_s3_r[g]  <= 1'b0;
					irq_lvl_r[g] <= 1'b0;
				end
				else
				begin
					irq_s1_r[g] <= port_irq_in[g];
					irq_s2_r[g] <= irq_s1_r[g];
					irq_s3_r[g] <= irq_s2_r[g];
					if (irq_s2_r[g] == irq_s3_r[g])
					begin
						irq_lvl_r[g] <= irq_s3_r[g];
					end
				end
			end
		end
	endgenerate

	always_ff @(posedge clk_sys_in)
	begin
		if (reset_in)
		begin
			mode_r      <= MMG_MONITOR;
			deadstart_r <= 1'b1;
			cause_r     <= MMG_C_NONE;
			irq_r       <= 1'b0;
		end
		else
		begin
			mode_r  <= mode_nxt;
			cause_r <= cause_nxt;
			irq_r   <= take_irq;
			if (exec_start_in)
			begin
				deadstart_r <= 1'b0;
			end
		end
	end

	// bounds written only by the monitor
	always_ff @(posedge clk_sys_in)
	begin
		if (reset_in)
		begin
			bounds_r <= {4{MMG_BOUND_RST}};
		end
		else if (bounds_wr_in && in_monitor)
		begin
			bounds_r <= bounds_in;
		end
	end

	always_ff @(posedge clk_sys_in)
	begin
		if (reset_in)
		begin
			grant_r      <= '0;
			deny_r       <= 1'b0;
			port_grant_r <= 1'b0;
			port_deny_r  <= 1'b0;
		end
		else
		begin
			grant_r.valid <= req_in.valid && access_ok;
			grant_r.space <= req_in.space;
			grant_r.kind  <= req_in.kind;
			grant_r.phys  <= grant_phys;
			deny_r        <= req_in.valid && !access_ok;
			port_grant_r  <= port_req_in.valid && port_ok;
			port_deny_r   <= port_req_in.valid && !port_ok;
		end
	end

	assign grant_out        = grant_r;
	assign deny_out         = deny_r;
	assign port_grant_out   = port_grant_r;
	assign port_deny_out    = port_deny_r;
	assign interrupt_out    = irq_r;
	assign cause_out        = cause_r;
	assign monitor_mode_out = mode_r;
	assign deadstart_out    = deadstart_r;
	assign bounds_out       = bounds_r;

	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (reset_in);

	AST_JOB_MAIN_LOW: assert property (req_in.valid && !in_monitor && is_main && req_in.addr < MMG_MON_WORDS
		|=> deny_r && !grant_r.valid && irq_r)
		else $error("job reached reserved main region");
	AST_MON_FETCH: assert property (req_in.valid && in_monitor && req_in.kind == MMG_K_FETCH
		&& !(is_main && req_in.addr < MMG_MON_FETCH) |=> deny_r && !irq_r)
		else $error("monitor fetch outside limit granted");
	AST_MON_DATA: assert property (req_in.valid && in_monitor && req_in.kind != MMG_K_FETCH
		|=> grant_r.valid && grant_r.phys == $past(req_in.addr))
		else $error("monitor data access not granted absolute");
	AST_PORT_IRQ: assert property (!in_monitor && !job_fault && port_irq_any |=> irq_r && in_monitor && cause_r == MMG_C_PORT)
		else $error("port interrupt not taken");
	AST_NO_IRQ_MON: assert property (in_monitor |=> !irq_r)
		else $error("interrupt accepted in monitor mode");
	AST_ABSENT: assert property (req_in.valid && !in_monitor && is_back && !back_pres
		|=> irq_r && cause_r == MMG_C_ABSENT)
		else $error("absent backing block did not interrupt");
	AST_MOVE_OVER: assert property (req_in.valid && !in_monitor && is_inter && req_in.kind == MMG_K_MOVE
		&& !inter_pres |=> irq_r ##1 in_monitor)
		else $error("move beyond intermediate did not interrupt");
	AST_BOUNDS_HOLD: assert property (!in_monitor |=> $stable(bounds_r))
		else $error("bounds changed in job mode");
	AST_KERNEL: assert property (port_req_in.valid && !deadstart_r && port_req_in.addr < MMG_KERNEL_WORDS
		|=> port_deny_r && !port_grant_r)
		else $error("port reached kernel after start");
	AST_DEADSTART: assert property (port_req_in.valid && deadstart_r |=> port_grant_r)
		else $error("port refused during deadstart");
	AST_RELOC: assert property (req_in.valid && !in_monitor && is_inter && job_inter_ok
		|=> grant_r.valid && grant_r.phys == $past(bounds_r.inter_lower) + $past(req_in.addr))
		else $error("intermediate relocation wrong");
	AST_EXCLUSIVE: assert property (!(grant_r.valid && deny_r))
		else $error("grant and deny together");
	AST_FAULT: assert property (job_fault |=> deny_r && irq_r)
		else $error("out of bounds job access not trapped");

	COV_PORT_IRQ: cover property (!in_monitor && port_irq_any ##1 irq_r);
	COV_JOB_GRANT: cover property (req_in.valid && !in_monitor && is_back ##1 grant_r.valid);
	COV_KERNEL_DENY: cover property (port_req_in.valid && !deadstart_r ##1 port_deny_r);
	COV_EXIT: cover property (in_monitor && monitor_exit_in ##1 !in_monitor);
endmodule : mmg_guard
`default_nettype wire

// ### src/mmg_pkg.sv
/*
 Package for the monitor memory guard. It holds the address limits,
 the reset values, the access codes and the carrier structs.
 It assumes word addresses of 32 bits in every memory level.
*/
`default_nettype none
package mmg_pkg;
	localparam int          MMG_AW          = 32;
	localparam int          MMG_NPORTS      = 4;
	// reserved monitor region, low words of main and intermediate memory
	localparam logic [31:0] MMG_MON_WORDS   = 32'h0001_0000;
	// monitor instruction fetch limit (65,636 words)
	localparam logic [31:0] MMG_MON_FETCH   = 32'h0001_0064;
	// kernel area closed to port controllers after deadstart
	localparam logic [31:0] MMG_KERNEL_WORDS = 32'h0000_8000;
	localparam logic [31:0] MMG_BOUND_RST   = 32'h0000_0000;

	typedef enum logic [1:0] {MMG_SP_MAIN, MMG_SP_INTER, MMG_SP_BACKING} mmg_space_type;
	typedef enum logic [1:0] {MMG_K_FETCH, MMG_K_READ, MMG_K_WRITE, MMG_K_MOVE} mmg_kind_type;
	typedef enum logic [1:0] {MMG_C_NONE, MMG_C_PORT, MMG_C_ABSENT, MMG_C_BOUNDS} mmg_cause_type;
	typedef enum logic {MMG_JOB, MMG_MONITOR} mmg_mode_type;

	typedef struct packed
	{
		logic          valid;
		mmg_space_type space;
		mmg_kind_type  kind;
		logic [31:0]   addr;
	} mmg_req_type;

	typedef struct packed
	{
		logic          valid;
		mmg_space_type space;
		mmg_kind_type  kind;
		logic [31:0]   phys;
	} mmg_grant_type;

	typedef struct packed
	{
		logic [31:0] inter_lower;
		logic [31:0] inter_upper;
		logic [31:0] backing_lower;
		logic [31:0] backing_upper;
	} mmg_bounds_type;

	typedef struct packed
	{
		logic        valid;
		logic        write;
		logic [31:0] addr;
	} mmg_port_req_type;
endpackage : mmg_pkg
`default_nettype wire

// ### src/mmg_reloc.sv
/*
 Relocation and bounds check for one relocated memory level.
 Purely combinational; the caller registers the results.
*/
`timescale 1ns/100ps
`default_nettype none
module mmg_reloc
(
	input  wire logic [31:0] offset_in,
	input  wire logic [31:0] lower_in,
	input  wire logic [31:0] upper_in,
	input  wire logic [31:0] installed_in,
	output logic      [31:0] phys_out,
	output logic             in_bounds_out,
	output logic             present_out
);
	import mmg_pkg::*;

	wire logic [32:0] sum;
	wire logic        carry;

	// job address is an offset from the level's lower bound
	assign sum           = {1'b0, lower_in} + {1'b0, offset_in};
	assign carry         = sum[32];
	assign phys_out      = sum[31:0];
	assign in_bounds_out = !carry && (phys_out >= lower_in) && (phys_out <= upper_in);
	// zero installed words means the level is absent
	assign present_out   = !carry && (installed_in != 32'h0000_0000) && (phys_out < installed_in);
endmodule : mmg_reloc
`default_nettype wire

// ### testbench/mmg_port_model.sv
/*
 Port controller model: raises interrupt lines at a clock edge and makes
 intermediate-memory accesses. Assumes one-cycle answers from the guard.
*/
`timescale 1ns/100ps
`default_nettype none
module mmg_port_model
(
	input  wire logic                      clk_sys_in,
	input  wire logic                      port_grant_in,
	input  wire logic                      port_deny_in,
	output logic [mmg_pkg::MMG_NPORTS-1:0] port_irq_out,
	output mmg_pkg::mmg_port_req_type      port_req_out
);
	import mmg_pkg::*;
	initial
	begin
		port_irq_out = '0;
		port_req_out = '{1'b0, 1'b0, 32'h0000_0000};
	end
	// level held until the next raise call; nothing here lowers it
	task automatic raise(input logic [MMG_NPORTS-1:0] lines);
		@(posedge clk_sys_in);
		port_irq_out <= lines;
	endtask : raise
	// one access; the released address shows its inverse
	task automatic access(input logic wr, input logic [31:0] a, output logic g, output logic d);
		@(posedge clk_sys_in);
		port_req_out <= '{1'b1, wr, a};
		@(posedge clk_sys_in);
		port_req_out <= '{1'b0, ~wr, ~a};
		#5;
		g = port_grant_in;
		d = port_deny_in;
	endtask : access
endmodule : mmg_port_model
`default_nettype wire

// ### testbench/tb.sv
/*
 Self-checking bench for the monitor memory guard: job requests and port
 accesses through tasks. Assumes all answers arrive one cycle after the request.
*/
`timescale 1ns/100ps
`default_nettype none
module tb;
	import mmg_pkg::*;
	typedef struct {mmg_space_type sp; mmg_kind_type k; logic [31:0] a; logic [31:0] bi; mmg_cause_type c;} mmg_fault_type;
	logic             clk_sys    = 1'b0;
	logic             reset      = 1'b1;
	logic             exec_start = 1'b0;
	logic             mon_exit   = 1'b0;
	logic             bounds_wr  = 1'b0;
	mmg_bounds_type   bounds     = '0;
	mmg_bounds_type   jb         = '{32'h0002_0000, 32'h0003_0000, 32'h0000_0100, 32'h0000_01FF};
	logic [31:0]      back_inst  = 32'h0001_0000;
	logic [31:0]      inter_inst = 32'h0002_8000;
	mmg_req_type      req        = '0;
	mmg_port_req_type port_req;
	logic [3:0]       port_irq;
	mmg_grant_type    grant;
	mmg_cause_type    cause;
	mmg_bounds_type   bounds_q;
	logic             deny, port_grant, port_deny, irq, mon, dstart, g, d;
	int               fail_count = 0;
	int               num_checks = 0;
	mmg_fault_type    ft [6] = '{
		'{MMG_SP_MAIN, MMG_K_FETCH, 32'h0000_FFFF, 32'h0001_0000, MMG_C_BOUNDS},
		'{MMG_SP_INTER, MMG_K_READ, 32'h0001_0001, 32'h0001_0000, MMG_C_ABSENT},
		'{MMG_SP_BACKING, MMG_K_WRITE, 32'h0000_0100, 32'h0001_0000, MMG_C_BOUNDS},
		'{MMG_SP_INTER, MMG_K_MOVE, 32'h0000_8000, 32'h0001_0000, MMG_C_ABSENT},
		'{MMG_SP_BACKING, MMG_K_MOVE, 32'h0000_0080, 32'h0000_0180, MMG_C_ABSENT},
		'{MMG_SP_BACKING, MMG_K_READ, 32'h0000_0000, 32'h0000_0000, MMG_C_ABSENT}};
	always #25 clk_sys = ~clk_sys;
	mmg_guard dut
	(
		.clk_sys_in           (clk_sys),
		.reset_in             (reset),
		.exec_start_in        (exec_start),
		.monitor_exit_in      (mon_exit),
		.port_irq_in          (port_irq),
		.bounds_wr_in         (bounds_wr),
		.bounds_in            (bounds),
		.inter_installed_in   (inter_inst),
		.backing_installed_in (back_inst),
		.req_in               (req),
		.port_req_in          (port_req),
		.grant_out            (grant),
		.deny_out             (deny),
		.port_grant_out       (port_grant),
		.port_deny_out        (port_deny),
		.interrupt_out        (irq),
		.cause_out            (cause),
		.monitor_mode_out     (mon),
		.deadstart_out        (dstart),
		.bounds_out           (bounds_q)
	);
	mmg_port_model port_model
	(
		.clk_sys_in    (clk_sys),
		.port_grant_in (port_grant),
		.port_deny_in  (port_deny),
		.port_irq_out  (port_irq),
		.port_req_out  (port_req)
	);
	task automatic chk_val(input string n, input logic [127:0] e, input logic [127:0] s);
		num_checks++;
		if (s !== e)
		begin
			fail_count++;
			$display("mismatch %s expected %0h seen %0h", n, e, s);
		end
	endtask : chk_val
	task automatic chk_flag(input string n, input logic e, input logic s);
		num_checks++;
		if (s !== e)
		begin
			fail_count++;
			$display("mismatch %s expected %b seen %b", n, e, s);
		end
	endtask : chk_flag
	task automatic complete_run;
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : complete_run
	task automatic job(input mmg_space_type sp, input mmg_kind_type k, input logic [31:0] a, input logic ok,
		input logic [31:0] phys, input logic fault);
		@(posedge clk_sys);
		req <= '{1'b1, sp, k, a};
		@(posedge clk_sys);
		req <= '{1'b0, sp, k, ~a};
		#5;
		chk_flag("grant", ok, grant.valid);
		chk_flag("deny", !ok, deny);
		chk_flag("interrupt", fault, irq);
		if (ok)
		begin
			chk_val("phys", phys, grant.phys);
			chk_val("space", sp, grant.space);
			chk_val("kind", k, grant.kind);
		end
	endtask : job
	task automatic to_job;
		@(posedge clk_sys);
		mon_exit <= 1'b1;
		@(posedge clk_sys);
		mon_exit <= 1'b0;
		#5;
		chk_flag("mode", 1'b0, mon);
	endtask : to_job
	task automatic pacc(input logic wr, input logic [31:0] a, input logic ok);
		port_model.access(wr, a, g, d);
		chk_flag("port grant", ok, g);
		chk_flag("port deny", !ok, d);
	endtask : pacc
	task automatic setb(input mmg_bounds_type b);
		@(posedge clk_sys);
		bounds <= b;
		bounds_wr <= 1'b1;
		@(posedge clk_sys);
		bounds_wr <= 1'b0;
		#5;
	endtask : setb
	initial
	begin
		repeat (6) @(posedge clk_sys);
		reset <= 1'b0;
		#5;
		chk_flag("monitor", 1'b1, mon);
		chk_flag("deadstart", 1'b1, dstart);
		chk_val("bounds", '0, bounds_q);
		chk_val("cause", MMG_C_NONE, cause);
		pacc(1'b1, 32'h0000_0100, 1'b1);
		pacc(1'b0, 32'h0000_7FFF, 1'b1);
		job(MMG_SP_MAIN, MMG_K_FETCH, 32'h0001_0063, 1'b1, 32'h0001_0063, 1'b0);
		job(MMG_SP_MAIN, MMG_K_FETCH, 32'h0001_0064, 1'b0, 32'h0, 1'b0);
		job(MMG_SP_INTER, MMG_K_FETCH, 32'h0000_0000, 1'b0, 32'h0, 1'b0);
		job(MMG_SP_INTER, MMG_K_READ, 32'hFFFF_0000, 1'b1, 32'hFFFF_0000, 1'b0);
		job(MMG_SP_BACKING, MMG_K_WRITE, 32'h0000_0005, 1'b1, 32'h0000_0005, 1'b0);
		setb(jb);
		chk_val("bounds", jb, bounds_q);
		@(posedge clk_sys);
		exec_start <= 1'b1;
		@(posedge clk_sys);
		#5;
		chk_flag("deadstart", 1'b0, dstart);
		pacc(1'b1, 32'h0000_0000, 1'b0);
		pacc(1'b0, 32'h0000_7FFF, 1'b0);
		pacc(1'b1, 32'h0000_8000, 1'b1);
		to_job;
		setb('1);
		chk_val("bounds", jb, bounds_q);
		job(MMG_SP_MAIN, MMG_K_READ, 32'h0001_0000, 1'b1, 32'h0001_0000, 1'b0);
		job(MMG_SP_INTER, MMG_K_READ, 32'h0000_0005, 1'b1, 32'h0002_0005, 1'b0);
		job(MMG_SP_BACKING, MMG_K_WRITE, 32'h0000_00FF, 1'b1, 32'h0000_01FF, 1'b0);
		// faults each enter monitor mode
		foreach (ft[i])
		begin
			@(posedge clk_sys);
			back_inst <= ft[i].bi;
			job(ft[i].sp, ft[i].k, ft[i].a, 1'b0, 32'h0, 1'b1);
			chk_val("cause", ft[i].c, cause);
			chk_flag("monitor", 1'b1, mon);
			to_job;
		end
		port_model.raise(4'h4);
		d = 1'b0;
		repeat (8)
		begin
			@(posedge clk_sys);
			#5;
			d = d | irq;
		end
		chk_flag("port interrupt", 1'b1, d);
		chk_val("cause", MMG_C_PORT, cause);
		chk_flag("monitor", 1'b1, mon);
		g = 1'b0;
		repeat (10)
		begin
			@(posedge clk_sys);
			#5;
			g = g | irq;
		end
		chk_flag("masked interrupt", 1'b0, g);
		complete_run;
	end
	initial
	begin
		repeat (2000) @(posedge clk_sys);
		fail_count++;
		complete_run;
	end
endmodule : tb
`default_nettype wire
